// ===== core/trigger_sequencer.v
// layered trigger sequencer: idle, initiate, two event-detection layers
// (arm, then trigger) and a sequence-operation state, with an
// AXI4-Lite register slave. assumes inputs synchronous to aclk.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "trig_map.vh"

module trigger_sequencer (
	input wire aclk,
	input wire aresetn,
	input wire [5:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [5:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire ext_trig, // external trigger pin
	input wire group_exec_trig, // group execute message pulse
	input wire [11:0] ana_int, // internal analog sample
	input wire [11:0] ana_ext, // external analog sample
	output reg action_start, // one-cycle pulse: begin the action
	input wire action_done, // action hardware reports completion
	output reg op_pending // operation pending flag
);

	// one-hot states
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_INIT = 5'h02;
	localparam [4:0] ST_ARM = 5'h04;
	localparam [4:0] ST_TRIG = 5'h08;
	localparam [4:0] ST_SEQ = 5'h10;

	// programmed settings
	reg cont; // continuous initiation
	reg [5:0] src; // two 3-bit source selects
	reg [31:0] count_set; // two 16-bit exit counts
	reg [49:0] ana_cfg; // two 25-bit analog settings
	reg [15:0] timer_period;

	// sequencer state
	reg [4:0] state;
	reg [4:0] next_state;
	reg upward; // arrived on the upward path
	reg next_upward;
	reg [31:0] done_cnt; // two 16-bit downward exit counters
	reg ext_prev; // last ext_trig sample
	reg [15:0] timer_cnt;
	reg timer_tick;

	// bus slave holding registers
	reg aw_hold;
	reg w_hold;
	reg [5:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	// command pulses decoded from a write to the command register
	wire do_write;
	wire cmd_hit;
	wire cmd_init;
	wire cmd_abort;
	wire cmd_reset;
	wire bus_trig;
	wire [1:0] ovr;
	wire [1:0] ev; // qualified event per layer
	wire [1:0] ev_ok; // event or one-shot override
	wire [1:0] in_layer;
	wire [1:0] reached;
	wire [1:0] down_exit;
	wire [1:0] down_enter;
	wire ext_rise;
	// merged write words, cut to each register's own width below
	wire [31:0] m_count0;
	wire [31:0] m_count1;
	wire [31:0] m_ana0;
	wire [31:0] m_ana1;
	wire [31:0] m_timer;

	assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
	assign cmd_hit = do_write & (aw_addr == `OFS_CMD) & w_strb[0];
	assign cmd_init = cmd_hit & w_data[`CMD_INIT];
	assign cmd_abort = cmd_hit & w_data[`CMD_ABORT];
	assign cmd_reset = cmd_hit & w_data[`CMD_RESET];
	// a group execute message or a trigger command
	assign bus_trig = (cmd_hit & w_data[`CMD_BUS_TRIG]) | group_exec_trig;
	assign ovr = cmd_hit ? w_data[`CMD_OVR1:`CMD_OVR0] : 2'b00;
	assign ext_rise = ext_trig & ~ext_prev;
	assign m_count0 = merge({16'h0000, count_set[15:0]}, w_data, w_strb);
	assign m_count1 = merge({16'h0000, count_set[31:16]}, w_data, w_strb);
	assign m_ana0 = merge({7'h00, ana_cfg[24:0]}, w_data, w_strb);
	assign m_ana1 = merge({7'h00, ana_cfg[49:25]}, w_data, w_strb);
	assign m_timer = merge({16'h0000, timer_period}, w_data, w_strb);
	assign in_layer = {state == ST_TRIG, state == ST_ARM};
	// exit edges feed the per-layer counters
	assign down_exit[0] = (state == ST_ARM) & (next_state == ST_TRIG);
	assign down_exit[1] = (state == ST_TRIG) & (next_state == ST_SEQ);
	assign down_enter[0] = (state == ST_INIT) & (next_state == ST_ARM);
	assign down_enter[1] = down_exit[0];

	// per-layer detection, override and exit counting
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : layer
			event_qualifier u_qual (
				.aclk(aclk),
				.aresetn(aresetn),
				.sel(src[gi*3+2:gi*3]),
				.bus_trig(bus_trig),
				.timer_tick(timer_tick),
				.ext_rise(ext_rise),
				.ana_int(ana_int),
				.ana_ext(ana_ext),
				.level(ana_cfg[gi*25+11:gi*25]),
				.hyst(ana_cfg[gi*25+23:gi*25+12]),
				.slope_neg(ana_cfg[gi*25+24]),
				.event_hit(ev[gi])
			);
			// override counts only while in its own layer
			assign ev_ok[gi] = ev[gi] | (ovr[gi] & in_layer[gi]);
			assign reached[gi] =
				done_cnt[gi*16+15:gi*16] >= count_set[gi*16+15:gi*16];
			// restart on downward entry, count each downward exit
			always @(posedge aclk) begin
				if (!aresetn) begin
					done_cnt[gi*16+15:gi*16] <= 16'h0000;
				end else if (down_enter[gi]) begin
					done_cnt[gi*16+15:gi*16] <= 16'h0000;
				end else if (down_exit[gi]) begin
					done_cnt[gi*16+15:gi*16] <=
						done_cnt[gi*16+15:gi*16] + 16'h0001;
				end
			end
		end
	endgenerate

	// next state: each case branch names only an adjacent state; abort and reset go straight to idle
	always @* begin
		next_state = state;
		next_upward = upward;
		case (state)
			ST_IDLE: begin
				if (cmd_init | cont) begin
					next_state = ST_INIT;
					next_upward = 1'b0;
				end
			end
			ST_INIT: begin
				if (!upward | cont) begin
					next_state = ST_ARM;
					next_upward = 1'b0;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_ARM: begin
				if (upward && reached[0]) begin
					next_state = ST_INIT; // count met
				end else if (ev_ok[0]) begin
					next_state = ST_TRIG;
					next_upward = 1'b0;
				end else begin
					next_upward = 1'b0; // back on the downward path
				end
			end
			ST_TRIG: begin
				if (upward && reached[1]) begin
					next_state = ST_ARM;
				end else if (ev_ok[1]) begin
					next_state = ST_SEQ;
					next_upward = 1'b0;
				end else begin
					next_upward = 1'b0;
				end
			end
			ST_SEQ: begin
				if (action_done && !action_start) begin
					next_state = ST_TRIG;
					next_upward = 1'b1;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_upward = 1'b0;
			end
		endcase
		if (cmd_abort | cmd_reset) begin
			next_state = ST_IDLE;
			next_upward = 1'b0;
		end
	end

	// state, pending flag and action start
	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			upward <= 1'b0;
			op_pending <= 1'b0;
			action_start <= 1'b0;
		end else begin
			state <= next_state;
			upward <= next_upward;
			op_pending <= (next_state != ST_IDLE);
			// started in the cycle the state reaches operation
			action_start <= (next_state == ST_SEQ) & (state != ST_SEQ);
		end
	end

	// edge detector and free-running source timer
	always @(posedge aclk) begin
		if (!aresetn) begin
			ext_prev <= 1'b0;
			timer_cnt <= 16'h0000;
			timer_tick <= 1'b0;
		end else begin
			ext_prev <= ext_trig;
			timer_tick <= (timer_cnt >= timer_period);
			if (timer_cnt >= timer_period) begin
				timer_cnt <= 16'h0000;
			end else begin
				timer_cnt <= timer_cnt + 16'h0001;
			end
		end
	end

	// byte-lane merge of a write into a stored word
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
			end
		end
	endfunction

	// settings; abort touches none of them
	always @(posedge aclk) begin
		if (!aresetn || cmd_reset) begin
			cont <= `RST_CONT;
			src <= {`SRC_IMM, `SRC_IMM};
			count_set <= {`RST_COUNT, `RST_COUNT};
			ana_cfg <= {`RST_SLOPE, `RST_HYST, `RST_LEVEL,
				`RST_SLOPE, `RST_HYST, `RST_LEVEL};
			timer_period <= `RST_TIMER;
		end else if (do_write) begin
			case (aw_addr)
				`OFS_CTRL: begin
					if (w_strb[0]) begin
						cont <= w_data[`CTRL_CONT];
					end
				end
				`OFS_SRC: begin
					if (w_strb[0]) src[2:0] <= w_data[`SRC0_LO+2:`SRC0_LO];
					if (w_strb[1]) src[5:3] <= w_data[`SRC1_LO+2:`SRC1_LO];
				end
				`OFS_COUNT0: count_set[15:0] <= m_count0[15:0];
				`OFS_COUNT1: count_set[31:16] <= m_count1[15:0];
				`OFS_ANA0: ana_cfg[24:0] <= m_ana0[24:0];
				`OFS_ANA1: ana_cfg[49:25] <= m_ana1[24:0];
				`OFS_TIMER: timer_period <= m_timer[15:0];
				default: begin
				end
			endcase
		end
	end

	// write channels: address and data taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 6'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= {s_axi_awaddr[5:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// status is read-only and holes are unmapped
				s_axi_bresp <= (aw_addr == `OFS_STATUS ||
					aw_addr > `OFS_TIMER) ? `RESP_SLVERR : `RESP_OKAY;
			end
			// ready again only after the response, so one write at a time
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read channel: data one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			case ({s_axi_araddr[5:2], 2'b00})
				`OFS_CTRL: s_axi_rdata <= {31'h0, cont};
				`OFS_CMD: s_axi_rdata <= 32'h0000_0000; // commands read 0
				`OFS_STATUS: s_axi_rdata <= {22'h0, upward, op_pending,
					3'h0, state};
				`OFS_SRC: s_axi_rdata <= {21'h0, src[5:3], 5'h00, src[2:0]};
				`OFS_COUNT0: s_axi_rdata <= {16'h0, count_set[15:0]};
				`OFS_COUNT1: s_axi_rdata <= {16'h0, count_set[31:16]};
				`OFS_ANA0: s_axi_rdata <= {7'h0, ana_cfg[24:0]};
				`OFS_ANA1: s_axi_rdata <= {7'h0, ana_cfg[49:25]};
				`OFS_TIMER: s_axi_rdata <= {16'h0, timer_period};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // trigger_sequencer

// ===== core/trig_map.vh
// register offsets, field positions, reset values and encodings
// of the layered trigger sequencer; definitions only, no logic.
// assumes a 32-bit AXI4-Lite register bus with one word per register.
`ifndef TRIG_MAP_VH
`define TRIG_MAP_VH

// byte offsets of the registers (low address bits [5:2] decoded)
`define OFS_CTRL 6'h00
`define OFS_CMD 6'h04
`define OFS_STATUS 6'h08
`define OFS_SRC 6'h0c
`define OFS_COUNT0 6'h10
`define OFS_COUNT1 6'h14
`define OFS_ANA0 6'h18
`define OFS_ANA1 6'h1c
`define OFS_TIMER 6'h20

// ctrl register fields
`define CTRL_CONT 0

// command register bits, each a one-shot on write of a one
`define CMD_INIT 0
`define CMD_ABORT 1
`define CMD_RESET 2
`define CMD_BUS_TRIG 3
`define CMD_OVR0 4
`define CMD_OVR1 5

// status register fields
`define STAT_STATE_HI 4
`define STAT_PENDING 8
`define STAT_UPWARD 9

// source field positions inside the src register, 3 bits each
`define SRC0_LO 0
`define SRC1_LO 8

// analog qualifier fields inside ana0 and ana1
`define ANA_LEVEL_LO 0
`define ANA_HYST_LO 12
`define ANA_SLOPE_NEG 24

// source encodings
`define SRC_IMM 3'h0
`define SRC_BUS 3'h1
`define SRC_TIMER 3'h2
`define SRC_EXT 3'h3
`define SRC_INT_ANA 3'h4
`define SRC_EXT_ANA 3'h5

// reset values
`define RST_CONT 1'b0
`define RST_COUNT 16'h0001
`define RST_LEVEL 12'h800
`define RST_HYST 12'h010
`define RST_SLOPE 1'b0
`define RST_TIMER 16'h00ff

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== core/event_qualifier.v
// event source selection and qualification for one event-detection layer.
// assumes all inputs synchronous to aclk; event_hit is a one-cycle level, held high for the immediate source.
`timescale 1ns/1ns
`include "trig_map.vh"

module event_qualifier (
	input wire aclk,
	input wire aresetn,
	input wire [2:0] sel, // selected source
	input wire bus_trig, // group execute or software trigger pulse
	input wire timer_tick, // periodic timer pulse
	input wire ext_rise, // rising edge of the external trigger pin
	input wire [11:0] ana_int, // internal analog sample
	input wire [11:0] ana_ext, // external analog sample
	input wire [11:0] level, // crossing level
	input wire [11:0] hyst, // hysteresis band
	input wire slope_neg, // 1 = falling crossing
	output reg event_hit // qualified event this cycle
);

	reg armed; // sample has left the hysteresis band
	wire [11:0] sample;
	wire [12:0] low_sum;
	wire [12:0] high_sum;
	wire rearm;
	wire crossed;

	assign sample = (sel == `SRC_EXT_ANA) ? ana_ext : ana_int;
	assign low_sum = {1'b0, sample} + {1'b0, hyst};
	assign high_sum = {1'b0, level} + {1'b0, hyst};
	// the band keeps noise around the level from firing twice
	assign rearm = slope_neg ? ({1'b0, sample} > high_sum) :
		(low_sum < {1'b0, level});
	assign crossed = slope_neg ? (sample <= level) : (sample >= level);

	// analog crossing detector
	always @(posedge aclk) begin
		if (!aresetn) begin
			armed <= 1'b0;
		end else if (sel != `SRC_INT_ANA && sel != `SRC_EXT_ANA) begin
			armed <= 1'b0; // digital source: detector idle
		end else if (armed && crossed) begin
			armed <= 1'b0; // one event per crossing
		end else if (rearm) begin
			armed <= 1'b1;
		end
	end

	// only the selected input may produce the event
	always @* begin
		case (sel)
			`SRC_IMM: event_hit = 1'b1;
			`SRC_BUS: event_hit = bus_trig;
			`SRC_TIMER: event_hit = timer_tick;
			`SRC_EXT: event_hit = ext_rise;
			`SRC_INT_ANA: event_hit = armed & crossed;
			`SRC_EXT_ANA: event_hit = armed & crossed;
			default: event_hit = 1'b0; // unused codes never fire
		endcase
	end

endmodule // event_qualifier

// ===== tb/seq_properties.sv
// port checker for the layered trigger sequencer
// assumes it is bound to trigger_sequencer and shares its one clock
`timescale 1ns/1ns
module seq_properties (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire action_start,
	input wire action_done,
	input wire op_pending
);
	// one domain, so one clock and one reset serve every property
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_rst_idle;
		$rose(aresetn) |-> !op_pending && !action_start;
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("sequencer busy right after reset");
	property p_start_pend;
		action_start |-> op_pending;
	endproperty
	a_start_pend: assert property (p_start_pend)
		else $error("action started while not pending");
	property p_start_pulse;
		action_start |=> !action_start;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("action start longer than one cycle");
	// pending cannot drop earlier than four steps back up through the layers
	property p_op_hold;
		action_start |=> op_pending [*4];
	endproperty
	a_op_hold: assert property (p_op_hold)
		else $error("left operation faster than layer by layer");
	// pending drops only after completion walked up, or on a command
	property p_pend_drop;
		$fell(op_pending) |-> s_axi_bvalid || $past(action_done, 4);
	endproperty
	a_pend_drop: assert property (p_pend_drop)
		else $error("pending dropped without completion or command");
	property p_b_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_busy: assert property (p_b_busy)
		else $error("write channels ready while response pending");
	property p_r_busy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_r_busy: assert property (p_r_busy)
		else $error("read address ready while data pending");
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_done: assert property (p_b_done)
		else $error("write response repeated");
	property p_r_done;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_done: assert property (p_r_done)
		else $error("read data repeated");

	// main scenarios reached
	c_start: cover property (action_start);
	c_back_idle: cover property ($fell(op_pending));
	c_done: cover property (action_done && op_pending);
endmodule // seq_properties

// ===== tb/action_model.sv
// behavioural action hardware answering the sequencer's start pulse
// assumes start is a one-cycle pulse; lat of zero stalls for ever
`timescale 1ns/1ns
module action_model (
	input wire aclk,
	input wire action_start,
	input wire [7:0] lat,
	output reg action_done
);
	reg [7:0] cnt; // cycles left until completion
	reg run; // an action is in progress
	initial begin
		action_done = 1'b0;
		run = 1'b0;
		cnt = 8'h00;
	end
	// completion is a one-cycle pulse so it cannot be miscounted twice
	always @(posedge aclk) begin
		action_done <= 1'b0;
		if (action_start) begin // a new start restarts any stalled one
			run <= 1'b1;
			cnt <= lat;
		end else if (run && lat != 8'h00) begin
			if (cnt <= 8'h01) begin
				action_done <= 1'b1;
				run <= 1'b0;
			end
			cnt <= cnt - 8'h01;
		end
	end
endmodule // action_model

// ===== tb/testbench.sv
// self-checking bench: AXI4-Lite master, trigger stimulus, action model
// assumes the sequencer's register map and a 50 ns clock
`timescale 1ns/1ns
`include "trig_map.vh"
module testbench;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	reg s_axi_bready = 1'b1, s_axi_rready = 1'b1; // always accepting
	reg [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg ext_trig = 1'b0, group_exec_trig = 1'b0;
	reg [11:0] ana_int = 12'h000, ana_ext = 12'h000;
	reg [7:0] lat = 8'h04; // action latency, random per run
	wire s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire action_start, action_done, op_pending;
	reg [31:0] d, c, n0; // read data, exit count, start snapshot
	reg [1:0] rs; // last response code
	integer n_fail = 0, tests_run = 0, n_start = 0, cyc = 0, i, seed;
	// source and stimulus kind per run: imm, bus cmd, group exec,
	// ext edge, analog, override, timer
	localparam [41:0] T = {6'o00, 6'o11, 6'o12, 6'o33, 6'o44, 6'o15, 6'o20};

	trigger_sequencer dut (.*);
	action_model far (.aclk(aclk), .action_start(action_start),
		.lat(lat), .action_done(action_done));

	always #25 aclk = ~aclk;
	// counts action starts and cuts a hang short
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (action_start === 1'b1)
			n_start <= n_start + 1;
		if (cyc == 60000) begin
			n_fail = n_fail + 1;
			results;
		end
	end

	task results;
		begin
			if (n_fail == 0 && tests_run > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// each channel released at its own handshake edge
	task wr(input [5:0] a, input [31:0] v);
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			do begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while (s_axi_awvalid && !s_axi_awready ||
				s_axi_wvalid && !s_axi_wready);
			do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
			rs = s_axi_bresp;
		end
	endtask
	task rd(input [5:0] a);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			do @(posedge aclk); while (s_axi_arready !== 1'b1);
			s_axi_arvalid <= 1'b0;
			do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
			d = s_axi_rdata;
			rs = s_axi_rresp;
		end
	endtask
	task idle;
		do @(posedge aclk); while (op_pending !== 1'b0);
	endtask
	// one single-shot run with the trigger layer on the given source
	task go(input [2:0] src, input [2:0] kick, input [31:0] cnt);
		begin
			lat <= 8'($urandom % 40) + 8'd1;
			wr(`OFS_SRC, {21'h0, src, 8'h00});
			n0 = n_start;
			wr(`OFS_CMD, 32'h1);
			repeat (30) @(posedge aclk);
			if (kick != 3'h0) begin
				chk(n_start, n0);
				rd(`OFS_STATUS);
				chk(d & 32'h1ff, 32'h108);
				case (kick)
					3'h1: wr(`OFS_CMD, 32'h8);
					3'h2: group_exec_trig <= 1'b1;
					3'h3: ext_trig <= 1'b1;
					3'h4: ana_int <= 12'h800 + 12'($urandom % 2047);
					default: wr(`OFS_CMD, 32'h20);
				endcase
				repeat (3) @(posedge aclk);
				group_exec_trig <= 1'b0;
				ext_trig <= 1'b0;
				ana_int <= 12'h000;
			end
			idle;
			chk(n_start, n0 + cnt);
		end
	endtask

	initial begin
		seed = $urandom(49232);
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({31'h0, op_pending}, 32'h0);
		rd(`OFS_STATUS);
		chk(d & 32'h1ff, 32'h001);
		for (i = 0; i < 7; i = i + 1)
			go(T[i * 6 + 3 +: 3], T[i * 6 +: 3], 1);
		c = 2 + $urandom % 3;
		wr(`OFS_COUNT1, c);
		go(3'h0, 3'h0, c);
		// continuous mode leaves idle without an initiate command
		n0 = n_start;
		wr(`OFS_CTRL, 32'h1);
		while (n_start < n0 + 2 * c + 1) @(posedge aclk);
		wr(`OFS_CTRL, 32'h0);
		idle;
		// whole passes only: starts since continuous began, modulo count
		chk((n_start - n0) % c, 32'h0);
		// stalled action: stays in operation until abort
		lat <= 8'h00;
		n0 = n_start;
		wr(`OFS_CMD, 32'h1);
		while (n_start == n0) @(posedge aclk);
		repeat (10) @(posedge aclk);
		rd(`OFS_STATUS);
		chk(d & 32'h1ff, 32'h110);
		wr(`OFS_CMD, 32'h2);
		chk({31'h0, op_pending}, 32'h0);
		rd(`OFS_COUNT1);
		chk(d, c);
		// reset command in mid-run restores sources and single mode
		lat <= 8'h05;
		wr(`OFS_SRC, 32'h0102);
		wr(`OFS_CTRL, 32'h1);
		wr(`OFS_CMD, 32'h4);
		repeat (20) @(posedge aclk);
		chk({31'h0, op_pending}, 32'h0);
		rd(`OFS_SRC);
		chk(d, 32'h0);
		rd(`OFS_CTRL);
		chk(d, 32'h0);
		// unmapped read and read-only write are refused
		rd(6'h24);
		chk({d[29:0], rs}, {30'h0, `RESP_SLVERR});
		wr(`OFS_STATUS, 32'h0);
		chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
		results;
	end
endmodule // testbench

bind trigger_sequencer seq_properties u_chk (.*);
